// *** hw/sirb_pkg.sv ***
// Constants, field layouts and carrier types of the serial port register banks.
// Assumes a single 100 MHz clock domain and a byte-wide register port.
package sirb_pkg;
    localparam int          BANK_CNT      = 8;
    localparam int          REG_CNT       = 8;
    localparam logic [2:0]  OFF_BAUD_LO   = 3'h0;
    localparam logic [2:0]  OFF_BAUD_HI   = 3'h1;
    localparam logic [2:0]  OFF_EXTENDED_CONTROL_1     = 3'h2;
    localparam logic [2:0]  OFF_BANK_SEL  = 3'h3;
    localparam logic [2:0]  OFF_EXTENDED_CONTROL_2     = 3'h4;
    localparam logic [2:0]  OFF_TX_FIFO_LEVEL     = 3'h6;
    localparam logic [2:0]  OFF_RX_FIFO_LEVEL     = 3'h7;
    localparam logic [2:0]  OFF_MOD_ID    = 3'h0;
    localparam logic [2:0]  OFF_LCR_SHDW  = 3'h1;
    localparam logic [2:0]  OFF_FCR_SHDW  = 3'h2;
    localparam logic [2:0]  OFF_IR_CONTROL_1     = 3'h2;
    localparam logic [2:0]  OFF_IR_CONTROL_2     = 3'h4;
    localparam logic [2:0]  OFF_IR_CONTROL_3     = 3'h0;
    localparam logic [2:0]  OFF_SIR_PULSE_WIDTH    = 3'h2;
    localparam logic [2:0]  OFF_DEMOD     = 3'h0;
    localparam logic [2:0]  OFF_MOD       = 3'h1;
    localparam logic [2:0]  OFF_CEIR      = 3'h2;
    localparam logic [2:0]  OFF_IR_INTERFACE_CONFIG_1    = 3'h4;
    localparam logic [2:0]  OFF_IR_INTERFACE_CONFIG_3    = 3'h6;
    localparam logic [2:0]  OFF_IR_INTERFACE_CONFIG_4    = 3'h7;
    // Writable bit masks; reserved bits are zero here
    localparam logic [7:0]  MASK_EXTENDED_CONTROL_1    = 8'hB9;
    localparam logic [7:0]  MASK_EXTENDED_CONTROL_2    = 8'hB0;
    localparam logic [7:0]  MASK_TX_FIFO_LEVEL    = 8'h0F;
    localparam logic [7:0]  MASK_RX_FIFO_LEVEL    = 8'h1F;
    localparam logic [7:0]  MASK_IR_CONTROL_1    = 8'h0C;
    localparam logic [7:0]  MASK_IR_CONTROL_2    = 8'h13;
    localparam logic [7:0]  MASK_IR_CONTROL_3    = 8'hC0;
    localparam logic [7:0]  MASK_SIR_PULSE_WIDTH   = 8'h0F;
    localparam logic [7:0]  MASK_IR_INTERFACE_CONFIG_3   = 8'h77;
    localparam logic [7:0]  MASK_IR_INTERFACE_CONFIG_4   = 8'hB8;
    localparam int          BANK_SELECT_ENABLE_BIT      = 7;
    localparam logic [7:0]  RST_VALUE     = 8'h00;

    typedef logic [2:0] sirb_bank_type;

    // Control state handed to the serial and infrared datapaths
    typedef struct packed {
        logic [15:0] baud_div;
        logic [7:0]  line_control;
        logic [7:0]  ext_ctrl1;
        logic [7:0]  ext_ctrl2;
        logic [3:0]  tx_fifo_lvl;
        logic [4:0]  rx_fifo_lvl;
        logic [7:0]  ir_ctrl1;
        logic [7:0]  ir_ctrl2;
        logic [7:0]  ir_ctrl3;
        logic [3:0]  pulse_width_field;
        logic [7:0]  ir_cfg1;
        logic [7:0]  ir_cfg3;
        logic [7:0]  ir_cfg4;
    } sirb_ctrl_type;

    // Read-only state reported by the datapaths
    typedef struct packed {
        logic [2:0]  demod_bandwidth;
        logic [4:0]  demod_frequency;
        logic [2:0]  carrier_pulse_width;
        logic [4:0]  carrier_frequency;
        logic [7:0]  ceir_config;
        logic [7:0]  fifo_control;
    } sirb_stat_type;
endpackage

// *** hw/sirb_bank_decode.sv ***
// Bank decoder for the line control / bank select byte.
// Assumes the byte comes straight from the register flip-flop.
`timescale 1ns/1ps
module sirb_bank_decode (
    // Register value
    input  wire logic [7:0]             sel_i,
    // Active bank
    output sirb_pkg::sirb_bank_type     bank_o
);
    import sirb_pkg::*;

    // Bank code map; unlisted codes with bits 7 and 6 set and bits 1:0 clear fall back to bank 0
    always_comb begin
        bank_o = 3'h0;
        if (sel_i[BANK_SELECT_ENABLE_BIT]) begin
            if (!sel_i[6] || sel_i[1] || sel_i[0]) begin
                bank_o = 3'h1;
            end else begin
                case (sel_i[5:0])
                    6'h20:   bank_o = 3'h2;
                    6'h24:   bank_o = 3'h3;
                    6'h28:   bank_o = 3'h4;
                    6'h2C:   bank_o = 3'h5;
                    6'h30:   bank_o = 3'h6;
                    6'h34:   bank_o = 3'h7;
                    default: bank_o = 3'h0;
                endcase
            end
        end
    end
endmodule

// *** hw/sirb_regs.sv ***
// Banked register file of the second serial port with its infrared controls.
// Assumes a byte register port with read data one cycle after the read strobe.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module sirb_regs #(
    parameter int         DATA_W      = 8,
    parameter logic [3:0] MODULE_ID   = 4'hA, // Arbitrary value
    parameter logic [3:0] REVISION_ID = 4'h1  // Arbitrary value
) (
    // Clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   resetn_i,
    // Register port
    input  wire logic [2:0]             addr_i,
    input  wire logic [DATA_W-1:0]      wdata_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    output logic      [DATA_W-1:0]      rdata_o,
    // Datapath state and controls
    input  sirb_pkg::sirb_stat_type     stat_i,
    output sirb_pkg::sirb_ctrl_type     ctrl_o,
    output sirb_pkg::sirb_bank_type     bank_o,
    // DMA requests and channel assignment
    input  wire logic                   dma_tx_req_i,
    input  wire logic                   dma_rx_req_i,
    input  wire logic [1:0]             dma_ch_en_i,
    output logic      [1:0]             dma_req_o
);
    import sirb_pkg::*;

    initial begin
        if (DATA_W != 8) begin
            $error("sirb_regs serves a byte-wide register port only");
        end
    end

    logic [7:0]     line_control_reg;
    logic [7:0]     baud_lo_reg;
    logic [7:0]     baud_hi_reg;
    logic [7:0]     extended_control_1_reg;
    logic [7:0]     extended_control_2_reg;
    logic [7:0]     tx_fifo_level_reg;
    logic [7:0]     rx_fifo_level_reg;
    logic [7:0]     ir_control_1_reg;
    logic [7:0]     ir_control_2_reg;
    logic [7:0]     ir_control_3_reg;
    logic [7:0]     sir_pulse_width_reg;
    logic [7:0]     ir_interface_config_1_reg;
    logic [7:0]     ir_interface_config_3_reg;
    logic [7:0]     ir_interface_config_4_reg;
    logic [7:0]     rdata_reg;
    logic [7:0]     rdata_next;
    sirb_bank_type  bank;

    // Access hit on one register of one bank
    function automatic logic hit(input sirb_bank_type b, input logic [2:0] a,
                                 input sirb_bank_type tb, input logic [2:0] ta);
        hit = (b == tb) && (a == ta);
    endfunction

    // Decode of the active bank from the shared register
    sirb_bank_decode u_bank_decode (
        .sel_i  (line_control_reg),
        .bank_o (bank)
    );

    // Shared line control / bank select, reachable in every bank
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            line_control_reg <= RST_VALUE;
        end else if (wr_i && addr_i == OFF_BANK_SEL) begin
            line_control_reg <= wdata_i;
        end
    end

    // Banks 1 to 2: baud divisor, bank 1 aliasing the legacy view
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            baud_lo_reg <= RST_VALUE;
            baud_hi_reg <= RST_VALUE;
        end else if (wr_i && (bank == 3'h1 || bank == 3'h2)) begin
            if (addr_i == OFF_BAUD_LO) begin
                baud_lo_reg <= wdata_i;
            end
            if (addr_i == OFF_BAUD_HI) begin
                baud_hi_reg <= wdata_i;
            end
        end
    end

    // Bank 2 extended controls and FIFO levels, reserved bits held at zero
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            extended_control_1_reg <= RST_VALUE;
            extended_control_2_reg <= RST_VALUE;
            tx_fifo_level_reg <= RST_VALUE;
            rx_fifo_level_reg <= RST_VALUE;
        end else if (wr_i) begin
            if (hit(bank, addr_i, 3'h2, OFF_EXTENDED_CONTROL_1)) begin
                extended_control_1_reg <= wdata_i & MASK_EXTENDED_CONTROL_1;
            end
            if (hit(bank, addr_i, 3'h2, OFF_EXTENDED_CONTROL_2)) begin
                extended_control_2_reg <= wdata_i & MASK_EXTENDED_CONTROL_2;
            end
            if (hit(bank, addr_i, 3'h2, OFF_TX_FIFO_LEVEL)) begin
                tx_fifo_level_reg <= wdata_i & MASK_TX_FIFO_LEVEL;
            end
            if (hit(bank, addr_i, 3'h2, OFF_RX_FIFO_LEVEL)) begin
                rx_fifo_level_reg <= wdata_i & MASK_RX_FIFO_LEVEL;
            end
        end
    end

    // Banks 4 to 6: infrared-only controls
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ir_control_1_reg  <= RST_VALUE;
            ir_control_2_reg  <= RST_VALUE;
            ir_control_3_reg  <= RST_VALUE;
            sir_pulse_width_reg <= RST_VALUE;
        end else if (wr_i) begin
            if (hit(bank, addr_i, 3'h4, OFF_IR_CONTROL_1)) begin
                ir_control_1_reg <= wdata_i & MASK_IR_CONTROL_1;
            end
            if (hit(bank, addr_i, 3'h5, OFF_IR_CONTROL_2)) begin
                ir_control_2_reg <= wdata_i & MASK_IR_CONTROL_2;
            end
            if (hit(bank, addr_i, 3'h6, OFF_IR_CONTROL_3)) begin
                ir_control_3_reg <= wdata_i & MASK_IR_CONTROL_3;
            end
            if (hit(bank, addr_i, 3'h6, OFF_SIR_PULSE_WIDTH)) begin
                sir_pulse_width_reg <= wdata_i & MASK_SIR_PULSE_WIDTH;
            end
        end
    end

    // Bank 7 writable interface configuration
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ir_interface_config_1_reg <= RST_VALUE;
            ir_interface_config_3_reg <= RST_VALUE;
            ir_interface_config_4_reg <= RST_VALUE;
        end else if (wr_i) begin
            if (hit(bank, addr_i, 3'h7, OFF_IR_INTERFACE_CONFIG_1)) begin
                ir_interface_config_1_reg <= wdata_i;
            end
            if (hit(bank, addr_i, 3'h7, OFF_IR_INTERFACE_CONFIG_3)) begin
                ir_interface_config_3_reg <= wdata_i & MASK_IR_INTERFACE_CONFIG_3;
            end
            if (hit(bank, addr_i, 3'h7, OFF_IR_INTERFACE_CONFIG_4)) begin
                ir_interface_config_4_reg <= wdata_i & MASK_IR_INTERFACE_CONFIG_4;
            end
        end
    end

    // Read multiplexer over bank and offset; unlisted places read zero
    always_comb begin
        rdata_next = 8'h00;
        if (addr_i == OFF_BANK_SEL) begin
            rdata_next = line_control_reg;
        end else begin
            case (bank)
                3'h1, 3'h2: begin
                    case (addr_i)
                        OFF_BAUD_LO: rdata_next = baud_lo_reg;
                        OFF_BAUD_HI: rdata_next = baud_hi_reg;
                        OFF_EXTENDED_CONTROL_1:   rdata_next = (bank == 3'h2) ? extended_control_1_reg : 8'h00;
                        OFF_EXTENDED_CONTROL_2:   rdata_next = (bank == 3'h2) ? extended_control_2_reg : 8'h00;
                        OFF_TX_FIFO_LEVEL:   rdata_next = (bank == 3'h2) ? tx_fifo_level_reg : 8'h00;
                        OFF_RX_FIFO_LEVEL:   rdata_next = (bank == 3'h2) ? rx_fifo_level_reg : 8'h00;
                        default:     rdata_next = 8'h00;
                    endcase
                end
                3'h3: begin
                    case (addr_i)
                        OFF_MOD_ID:   rdata_next = {MODULE_ID, REVISION_ID};
                        OFF_LCR_SHDW: rdata_next = line_control_reg;
                        OFF_FCR_SHDW: rdata_next = stat_i.fifo_control;
                        default:      rdata_next = 8'h00;
                    endcase
                end
                3'h4: rdata_next = (addr_i == OFF_IR_CONTROL_1) ? ir_control_1_reg : 8'h00;
                3'h5: rdata_next = (addr_i == OFF_IR_CONTROL_2) ? ir_control_2_reg : 8'h00;
                3'h6: begin
                    case (addr_i)
                        OFF_IR_CONTROL_3:  rdata_next = ir_control_3_reg;
                        OFF_SIR_PULSE_WIDTH: rdata_next = sir_pulse_width_reg;
                        default:    rdata_next = 8'h00;
                    endcase
                end
                3'h7: begin
                    case (addr_i)
                        OFF_DEMOD:  rdata_next = {stat_i.demod_bandwidth, stat_i.demod_frequency};
                        OFF_MOD:    rdata_next = {stat_i.carrier_pulse_width, stat_i.carrier_frequency};
                        OFF_CEIR:   rdata_next = stat_i.ceir_config;
                        OFF_IR_INTERFACE_CONFIG_1: rdata_next = ir_interface_config_1_reg;
                        OFF_IR_INTERFACE_CONFIG_3: rdata_next = ir_interface_config_3_reg;
                        OFF_IR_INTERFACE_CONFIG_4: rdata_next = ir_interface_config_4_reg;
                        default:    rdata_next = 8'h00;
                    endcase
                end
                default: rdata_next = 8'h00;
            endcase
        end
    end

    // Read data stands for the one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_reg <= RST_VALUE;
        end else begin
            rdata_reg <= rd_i ? rdata_next : 8'h00;
        end
    end

    // DMA routing: two channels split by direction, one channel carries both
    always_comb begin
        case (dma_ch_en_i)
            2'h3:    dma_req_o = {dma_tx_req_i, dma_rx_req_i};
            2'h1:    dma_req_o = {1'b0, dma_tx_req_i | dma_rx_req_i};
            2'h2:    dma_req_o = {dma_tx_req_i | dma_rx_req_i, 1'b0};
            default: dma_req_o = 2'h0;
        endcase
    end

    // Outputs from the register flip-flops, the bank through the decoder
    assign rdata_o = rdata_reg;
    assign bank_o  = bank;
    assign ctrl_o  = '{baud_div:          {baud_hi_reg, baud_lo_reg},
                       line_control:      line_control_reg,
                       ext_ctrl1:         extended_control_1_reg,
                       ext_ctrl2:         extended_control_2_reg,
                       tx_fifo_lvl:       tx_fifo_level_reg[3:0],
                       rx_fifo_lvl:       rx_fifo_level_reg[4:0],
                       ir_ctrl1:          ir_control_1_reg,
                       ir_ctrl2:          ir_control_2_reg,
                       ir_ctrl3:          ir_control_3_reg,
                       pulse_width_field: sir_pulse_width_reg[3:0],
                       ir_cfg1:           ir_interface_config_1_reg,
                       ir_cfg3:           ir_interface_config_3_reg,
                       ir_cfg4:           ir_interface_config_4_reg};

    // Checks on bank selection, read path and DMA routing
    bank_zero_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !line_control_reg[BANK_SELECT_ENABLE_BIT] |-> bank == 3'h0)
        else $error("bank not zero while bank select disabled");

    bank_next_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (wr_i && addr_i == OFF_BANK_SEL && wdata_i == 8'hE8) |=> bank == 3'h4)
        else $error("new bank not active on next access");

    bsr_read_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (rd_i && addr_i == OFF_BANK_SEL) |=> rdata_o == $past(line_control_reg))
        else $error("bank select not readable in current bank");

    reserved_zero_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (rd_i && addr_i == 3'h5) |=> rdata_o == 8'h00)
        else $error("reserved offset read non-zero");

    pulse_width_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (wr_i && bank == 3'h6 && addr_i == OFF_SIR_PULSE_WIDTH) ##1 rd_i && addr_i == OFF_SIR_PULSE_WIDTH && bank == 3'h6
        |=> rdata_o == {4'h0, $past(wdata_i[3:0], 2)})
        else $error("pulse width read back wrong");

    demod_read_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (rd_i && bank == 3'h7 && addr_i == OFF_DEMOD)
        |=> rdata_o == $past({stat_i.demod_bandwidth, stat_i.demod_frequency}))
        else $error("demodulator control read wrong");

    mod_read_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (rd_i && bank == 3'h7 && addr_i == OFF_MOD)
        |=> rdata_o == $past({stat_i.carrier_pulse_width, stat_i.carrier_frequency}))
        else $error("modulator control read wrong");

    ir_hidden_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (rd_i && bank == 3'h0 && addr_i != OFF_BANK_SEL) |=> rdata_o == 8'h00)
        else $error("infrared control visible in shared bank");

    dma_split_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        dma_ch_en_i == 2'h3 |-> dma_req_o == {dma_tx_req_i, dma_rx_req_i})
        else $error("two-channel routing wrong");

    dma_single_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        dma_ch_en_i == 2'h1 |-> dma_req_o == {1'b0, dma_tx_req_i | dma_rx_req_i})
        else $error("one-channel routing wrong");

endmodule

// *** testbench/sirb_dp_model.sv ***
// Datapath and DMA partner model beside the serial/infrared register file.
// Assumes one clock shared with the register file and an active-low reset.
`timescale 1ns/1ps
module sirb_dp_model
    import sirb_pkg::*;
(
    // Clock and reset
    input  wire logic               clk_i,
    input  wire logic               resetn_i,
    // Commands from the bench
    input  wire logic               refresh_i,
    input  wire logic [1:0]         dir_i,
    // Status and DMA requests toward the register file
    output sirb_pkg::sirb_stat_type stat_o,
    output logic                    tx_req_o,
    output logic                    rx_req_o
);
    // New random status word on each refresh, held steady otherwise
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            stat_o <= '0;
        end else if (refresh_i) begin
            stat_o <= sirb_stat_type'($urandom);
        end
    end

    // One direction for half-duplex traffic, both for full duplex
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_req_o <= 1'b0;
            rx_req_o <= 1'b0;
        end else begin
            tx_req_o <= dir_i[0];
            rx_req_o <= dir_i[1];
        end
    end
endmodule

// *** testbench/serial_ir_register_banks_tb_top.sv ***
// Self-checking bench for the banked serial/infrared register file.
// Assumes the design package, the register file and the datapath model are compiled first.
`timescale 1ns/1ps
module serial_ir_register_banks_tb_top;
    import sirb_pkg::*;
    localparam logic [3:0] TB_MID = 4'hA; // Arbitrary value
    localparam logic [3:0] TB_RID = 4'h1; // Arbitrary value
    localparam logic [7:0] CODES [0:14] = '{8'h00, 8'h80, 8'hE0, 8'hE4, 8'hE8, 8'hEC, 8'hF0, 8'hF4,
                                            8'h7F, 8'hBF, 8'hC1, 8'hC2, 8'hC0, 8'hF8, 8'hE1};
    logic          clk = 1'b0;
    logic          resetn, wr, rd, refresh, tx_req, rx_req, rd_seen;
    logic [2:0]    addr;
    logic [7:0]    wdata, rdata, lcr_m, lcr_d1;
    logic [1:0]    ch_en, dir, dma_req;
    sirb_stat_type stat;
    sirb_ctrl_type ctrl;
    sirb_bank_type bank;
    logic [7:0]    mirror [0:63];
    logic [7:0]    exp_q [$];
    int            err_count, cmp_count;

    always #5 clk = ~clk;

    sirb_regs #(.DATA_W(8), .MODULE_ID(TB_MID), .REVISION_ID(TB_RID)) i_dut (
        .clk_i(clk), .resetn_i(resetn), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .stat_i(stat), .ctrl_o(ctrl), .bank_o(bank), .dma_tx_req_i(tx_req),
        .dma_rx_req_i(rx_req), .dma_ch_en_i(ch_en), .dma_req_o(dma_req));

    sirb_dp_model i_model (
        .clk_i(clk), .resetn_i(resetn), .refresh_i(refresh), .dir_i(dir),
        .stat_o(stat), .tx_req_o(tx_req), .rx_req_o(rx_req));

    // Comparison with counting
    task automatic check(input logic [15:0] seen, input logic [15:0] expv);
        cmp_count++;
        if (seen !== expv) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, expv);
        end
    endtask

    task automatic give_verdict();
        if (err_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Bank chosen by a line control value
    function automatic int dec(input logic [7:0] v);
        if (!v[7]) return 0;
        if (!v[6] || v[1] || v[0]) return 1;
        case (v[5:0])
            6'h20: return 2;
            6'h24: return 3;
            6'h28: return 4;
            6'h2C: return 5;
            6'h30: return 6;
            6'h34: return 7;
            default: return 0;
        endcase
    endfunction

    // Writable bits of each place; zero for reserved and read-only places
    function automatic logic [7:0] wmask(input int b, input int o);
        case (b * 8 + o)
            8, 9, 16, 17, 60: return 8'hFF;
            18: return MASK_EXTENDED_CONTROL_1;
            20: return MASK_EXTENDED_CONTROL_2;
            22: return MASK_TX_FIFO_LEVEL;
            23: return MASK_RX_FIFO_LEVEL;
            34: return MASK_IR_CONTROL_1;
            44: return MASK_IR_CONTROL_2;
            48: return MASK_IR_CONTROL_3;
            50: return MASK_SIR_PULSE_WIDTH;
            62: return MASK_IR_INTERFACE_CONFIG_3;
            63: return MASK_IR_INTERFACE_CONFIG_4;
            default: return 8'h00;
        endcase
    endfunction

    // Bank 1 low offsets share storage with the bank 2 divisor
    function automatic int idx(input int b, input int o);
        return (b == 1 && o < 2) ? 16 + o : b * 8 + o;
    endfunction

    function automatic logic [7:0] exp_rd(input int b, input int o);
        if (o == 3) return lcr_m;
        case (b * 8 + o)
            24: return {TB_MID, TB_RID};
            25: return lcr_m;
            26: return stat.fifo_control;
            56: return {stat.demod_bandwidth, stat.demod_frequency};
            57: return {stat.carrier_pulse_width, stat.carrier_frequency};
            58: return stat.ceir_config;
            default: return mirror[idx(b, o)];
        endcase
    endfunction

    // Bus cycles; each occupies exactly one clock
    task automatic wr_reg(input logic [2:0] o, input logic [7:0] d);
        int b;
        b = dec(lcr_m);
        addr <= o;
        wdata <= d;
        wr <= 1'b1;
        rd <= 1'b0;
        if (o == 3'h3) lcr_m <= d; // Takes effect at once, one edge ahead of the register
        else mirror[idx(b, o)] = d & wmask(b, o);
        @(posedge clk);
    endtask

    task automatic rd_reg(input logic [2:0] o);
        int b;
        b = dec(lcr_m);
        addr <= o;
        wr <= 1'b0;
        rd <= 1'b1;
        exp_q.push_back(exp_rd(b, o));
        @(posedge clk);
    endtask

    task automatic idle();
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
    endtask

    // Output watcher: read data, idle zero and active bank
    always @(posedge clk) begin
        lcr_d1 <= lcr_m;
        rd_seen <= rd;
        if (resetn) begin
            check(16'(bank), 16'(dec(lcr_d1)));
            if (rd_seen && exp_q.size() > 0) check(rdata, exp_q.pop_front());
            else check(rdata, 8'h00);
        end
    end

    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        give_verdict();
    end

    initial begin
        {resetn, wr, rd, refresh, rd_seen} = '0;
        {addr, wdata, ch_en, dir, lcr_m, lcr_d1} = '0;
        err_count = 0;
        cmp_count = 0;
        foreach (mirror[i]) mirror[i] = 8'h00;
        void'($urandom(32'h86B31890));
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        // Each of the 15 select codes in CODES, read back at once through offset 3
        foreach (CODES[i]) begin
            wr_reg(3'h3, CODES[i]);
            rd_reg(3'h3);
        end
        // Each bank: fill with random data, read all eight places back
        for (int p = 0; p < 2; p++) begin
            refresh <= 1'b1;
            idle();
            refresh <= 1'b0;
            idle();
            for (int b = 0; b < 8; b++) begin
                wr_reg(3'h3, CODES[b]);
                for (int o = 0; o < 8; o++) if (o != 3) wr_reg(3'(o), 8'($urandom));
                for (int o = 0; o < 8; o++) rd_reg(3'(o));
            end
        end
        // Pulse width written and read back on consecutive cycles
        wr_reg(3'h3, CODES[6]);
        wr_reg(3'h2, 8'($urandom));
        rd_reg(3'h2);
        idle();
        check(16'(ctrl.pulse_width_field), 16'(mirror[50][3:0]));
        check(ctrl.baud_div, {mirror[17], mirror[16]});
        // Channel assignment against request directions
        for (int i = 0; i < 16; i++) begin
            ch_en <= 2'(i >> 2);
            dir <= 2'(i);
            idle();
            idle();
            case (i >> 2)
                3: check(16'(dma_req), 16'({i[0], i[1]}));
                2: check(16'(dma_req), 16'({i[0] | i[1], 1'b0}));
                1: check(16'(dma_req), 16'(i[0] | i[1]));
                default: check(16'(dma_req), 16'h0000);
            endcase
        end
        // Second reset in mid-run clears everything
        resetn <= 1'b0;
        lcr_m <= 8'h00;
        foreach (mirror[i]) mirror[i] = 8'h00;
        idle();
        resetn <= 1'b1;
        idle();
        check(16'(ctrl.pulse_width_field), 16'h0000);
        rd_reg(3'h3);
        idle();
        idle();
        check(16'(exp_q.size()), 16'h0000);
        give_verdict();
    end
endmodule
